// File: verilog/escb_pkg.sv
// How it works
// - writing one to the nonmaskable set bit pends it; read shows pending or active
// - nonmaskable request is taken next cycle, ahead of everything else
// - writing one to deferred service set pends it; read returns pending state
// - write-only deferred service clear removes its pending state; zero ignored
// - writing one to the tick set bit pends the tick; read returns state
// - without tick timer, set bit reads zero, ignores writes; clear reserved
// - tick clear removes pending whether software or timer hardware set it
// - with debug, bit shows a pending exception will be taken on halt exit
// - with debug, bit shows any external controller interrupt is pending
// - nine-bit field reports highest-priority pending exception number, zero if none
// - pending number honours enables and masks, ignores the priority mask special
// - with debug, nine-bit field gives running exception number, zero is thread
// - vector base holds offset in bits 31:7; bits 6:0 reserved zero
// - offset bits not built read zero and ignore writes
// - offset resets to zero unless configuration inputs give its reset value
// - all-ones write reads back only the built offset bits
// - pending control register at 0xE000ED04, resets to zero
// - vector base register at 0xE000ED08, read-write
package escb_pkg;
    localparam logic [31:0] ESCB_ADDR_PEND   = 32'hE000ED04;
    localparam logic [31:0] ESCB_ADDR_VBASE  = 32'hE000ED08;
    localparam int          ESCB_NMI_SET     = 31;
    localparam int          ESCB_DS_SET      = 28;
    localparam int          ESCB_DS_CLR      = 27;
    localparam int          ESCB_TK_SET      = 26;
    localparam int          ESCB_TK_CLR      = 25;
    localparam int          ESCB_HALT_SVC    = 23;
    localparam int          ESCB_EXT_PEND    = 22;
    localparam int          ESCB_TOP_LSB     = 12;
    localparam int          ESCB_RUN_LSB     = 0;
    localparam int          ESCB_NUM_W       = 9;
    localparam int          ESCB_OFF_LSB     = 7;
    localparam logic [31:0] ESCB_OFF_MASK    = 32'hFFFFFF80;
    localparam logic [31:0] ESCB_PEND_RESET  = 32'h00000000;
    localparam logic [31:0] ESCB_VBASE_RESET = 32'h00000000;
    localparam logic [8:0]  ESCB_NUM_NONE    = 9'h000;
endpackage

// File: verilog/escb_regs.sv
`timescale 1ns/1ps
// pending control and vector base registers, read/written over the core's
// system control space port; the pending number comes from the prioritiser
module escb_regs #(
    parameter bit          HAS_TICK        = 1'b1,
    parameter bit          HAS_DEBUG       = 1'b1,
    parameter logic [31:0] OFF_BUILT_MASK  = 32'hFFFFFF80,
    parameter bit          USE_CFG_RESET   = 1'b0
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        reg_sel,
    input  wire logic        reg_write,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_ready,
    input  wire logic [31:0] cfg_table_offset,
    input  wire logic        tick_hw_set,
    input  wire logic        nmi_taken,
    input  wire logic        deferred_service_taken,
    input  wire logic        tick_taken,
    input  wire logic        nmi_active,
    input  wire logic [8:0]  top_pending_number,
    input  wire logic        external_irq_pending,
    input  wire logic        service_on_halt_exit,
    input  wire logic [8:0]  program_status_exception,
    output logic             nonmaskable_pend_q,
    output logic             deferred_service_pend_q,
    output logic             tick_pend_q,
    output logic      [31:0] table_offset_q
);
    // only the built offset bits ever hold state; bits below the field stay reserved
    localparam logic [31:0] OFF_MASK =
        OFF_BUILT_MASK & escb_pkg::ESCB_OFF_MASK;

    // address match, shared by the write strobes and the read mux
    function automatic logic escb_addr_hit(
        input logic [31:0] addr,
        input logic [31:0] target
    );
        return addr == target;
    endfunction

    // next pend state: a set beats a clear or a take in the same cycle,
    // so a fresh request never vanishes before the prioritiser sees it
    function automatic logic escb_flag_next(
        input logic cur,
        input logic set,
        input logic clr
    );
        logic nxt;
        nxt = cur;
        if (set) begin
            nxt = 1'b1;
        end else if (clr) begin
            nxt = 1'b0;
        end
        return nxt;
    endfunction

    // keeps only the built offset bits of a value headed for the register
    function automatic logic [31:0] escb_offset_keep(
        input logic [31:0] value
    );
        return value & OFF_MASK;
    endfunction

    // pending register image; reserved bits, clear bits and absent options read zero
    function automatic logic [31:0] escb_pend_word(
        input logic       nmi_state,
        input logic       ds_state,
        input logic       tk_state,
        input logic [8:0] top_num,
        input logic       halt_svc,
        input logic       ext_pend,
        input logic [8:0] run_num
    );
        logic [31:0] word;
        word = 32'h00000000;
        word[escb_pkg::ESCB_NMI_SET] = nmi_state;
        word[escb_pkg::ESCB_DS_SET]  = ds_state;
        word[escb_pkg::ESCB_TK_SET]  = tk_state;
        word[escb_pkg::ESCB_TOP_LSB +: escb_pkg::ESCB_NUM_W] = top_num;
        // debug-only fields stay reserved when debug is not built
        if (HAS_DEBUG) begin
            word[escb_pkg::ESCB_HALT_SVC] = halt_svc;
            word[escb_pkg::ESCB_EXT_PEND] = ext_pend;
            word[escb_pkg::ESCB_RUN_LSB +: escb_pkg::ESCB_NUM_W] = run_num;
        end
        return word;
    endfunction

    // decoded register hits and access strobes
    logic        hit_pend;
    logic        hit_vbase;
    logic        wr_pend;
    logic        wr_vbase;
    logic        rd_access;

    // per-bit write requests; a zero in any of these bits does nothing
    logic        nmi_set_req;
    logic        ds_set_req;
    logic        ds_clr_req;
    logic        tk_set_req;
    logic        tk_clr_req;

    // combined set and clear causes, software, core and timer alike
    logic        ds_clr_any;
    logic        tk_set_any;
    logic        tk_clr_any;

    // read side
    logic        nmi_read;
    logic        tk_read;
    logic [31:0] pend_word;
    logic [31:0] rdata_d;

    // strap load marker after reset
    logic        cfg_loaded_q;

    // one compare per register, reused by write strobes and the read mux
    assign hit_pend  = escb_addr_hit(reg_addr, escb_pkg::ESCB_ADDR_PEND);
    assign hit_vbase = escb_addr_hit(reg_addr, escb_pkg::ESCB_ADDR_VBASE);

    // an access is one cycle of select; write picks the direction
    assign wr_pend   = reg_sel && reg_write && hit_pend;
    assign wr_vbase  = reg_sel && reg_write && hit_vbase;
    assign rd_access = reg_sel && !reg_write;

    // nonmaskable has a set bit only; the core's take clears it
    assign nmi_set_req = wr_pend && reg_wdata[escb_pkg::ESCB_NMI_SET];

    // deferred service set and write-only clear
    assign ds_set_req = wr_pend && reg_wdata[escb_pkg::ESCB_DS_SET];
    assign ds_clr_req = wr_pend && reg_wdata[escb_pkg::ESCB_DS_CLR];

    // tick set and clear; both dead when no timer is built
    assign tk_set_req = HAS_TICK && wr_pend && reg_wdata[escb_pkg::ESCB_TK_SET];
    assign tk_clr_req = HAS_TICK && wr_pend && reg_wdata[escb_pkg::ESCB_TK_CLR];

    // the core's take also clears; the timer hardware also sets the tick
    assign ds_clr_any = ds_clr_req || deferred_service_taken;
    assign tk_set_any = tk_set_req || (HAS_TICK && tick_hw_set);
    assign tk_clr_any = tk_clr_req || tick_taken;

    // nonmaskable pend; the prioritiser takes it in the same cycle it lands
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nonmaskable_pend_q <= escb_pkg::ESCB_PEND_RESET[escb_pkg::ESCB_NMI_SET];
        end else begin
            nonmaskable_pend_q <= escb_flag_next(nonmaskable_pend_q,
                                                 nmi_set_req,
                                                 nmi_taken);
        end
    end

    // deferred service pend; a both-ones write is undefined, set wins here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            deferred_service_pend_q <= escb_pkg::ESCB_PEND_RESET[escb_pkg::ESCB_DS_SET];
        end else begin
            deferred_service_pend_q <= escb_flag_next(deferred_service_pend_q,
                                                      ds_set_req,
                                                      ds_clr_any);
        end
    end

    // tick pend from software or timer; never leaves reset without a timer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_pend_q <= escb_pkg::ESCB_PEND_RESET[escb_pkg::ESCB_TK_SET];
        end else begin
            tick_pend_q <= escb_flag_next(tick_pend_q,
                                          tk_set_any,
                                          tk_clr_any);
        end
    end

    // strap load marker: set at the first edge after reset release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_loaded_q <= 1'b0;
        end else begin
            cfg_loaded_q <= 1'b1;
        end
    end

    // straps are caught by a clocked load so the reset branch stays constant;
    // the cost is that a write in that first cycle is lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            table_offset_q <= escb_pkg::ESCB_VBASE_RESET;
        end else if (!cfg_loaded_q && USE_CFG_RESET) begin
            table_offset_q <= escb_offset_keep(cfg_table_offset);
        end else if (cfg_loaded_q && wr_vbase) begin
            table_offset_q <= escb_offset_keep(reg_wdata);
        end
    end

    // nonmaskable reads as set while pending or already running
    assign nmi_read = nonmaskable_pend_q || nmi_active;

    // absent timer reads zero whatever the flop holds
    assign tk_read = HAS_TICK && tick_pend_q;

    // prioritiser number already honours enables, not the special mask
    assign pend_word = escb_pend_word(nmi_read,
                                      deferred_service_pend_q,
                                      tk_read,
                                      top_pending_number,
                                      service_on_halt_exit,
                                      external_irq_pending,
                                      program_status_exception);

    // read mux; unmapped addresses return zero
    always_comb begin
        rdata_d = 32'h00000000;
        if (hit_pend) begin
            rdata_d = pend_word;
        end else if (hit_vbase) begin
            rdata_d = table_offset_q;
        end
    end

    // read data registered one cycle after select, zero when not a read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (rd_access) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ready pulse for every select, read or write alike
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_ready <= 1'b0;
        end else begin
            reg_ready <= reg_sel;
        end
    end
endmodule

// File: verif/escb_partner.sv
`timescale 1ns/1ps
// stand-in prioritiser: takes nmi at once, leaves the others pending
module escb_partner #(
    parameter logic [8:0] DS_NUM = 9'h00E,
    parameter logic [8:0] TK_NUM = 9'h00F
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       nonmaskable_pend_q,
    input  wire logic       deferred_service_pend_q,
    input  wire logic       tick_pend_q,
    output logic            nmi_taken,
    output logic            nmi_active,
    output logic      [8:0] top_pending_number
);
    // nmi outranks all, so no arbitration delay
    assign nmi_taken = nonmaskable_pend_q;
    // active never drops here; the bench runs no handler return
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nmi_active <= 1'b0;
        end else if (nmi_taken) begin
            nmi_active <= 1'b1;
        end
    end
    // priority mask special plays no part in the choice
    assign top_pending_number = deferred_service_pend_q ? DS_NUM :
                                tick_pend_q ? TK_NUM : 9'h000;
endmodule

// File: verif/escb_regs_chk.sv
`timescale 1ns/1ps
module escb_chk #(
    parameter logic [31:0] OFF_BUILT_MASK = 32'hFFFFFF80,
    parameter bit          HAS_TICK       = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        reg_sel,
    input  wire logic        reg_write,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        tick_hw_set,
    input  wire logic [8:0]  top_pending_number,
    input  wire logic        nonmaskable_pend_q,
    input  wire logic        deferred_service_pend_q,
    input  wire logic        tick_pend_q,
    input  wire logic [31:0] table_offset_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // decoded accesses to the pending control register
    wire wp = reg_sel && reg_write && reg_addr == escb_pkg::ESCB_ADDR_PEND;
    wire rp = reg_sel && !reg_write && reg_addr == escb_pkg::ESCB_ADDR_PEND;
    nmi_set_a: assert property (wp && reg_wdata[31] |=> nonmaskable_pend_q)
        else $error("nmi set lost");
    ds_set_a: assert property (wp && reg_wdata[28] |=> deferred_service_pend_q)
        else $error("deferred set lost");
    ds_clear_a: assert property (wp && reg_wdata[27] && !reg_wdata[28]
        |=> !deferred_service_pend_q) else $error("deferred clear lost");
    tick_set_a: assert property (HAS_TICK && wp && reg_wdata[26] |=> tick_pend_q)
        else $error("tick set lost");
    tick_clear_a: assert property (wp && reg_wdata[25] && !reg_wdata[26] && !tick_hw_set
        |=> !tick_pend_q) else $error("tick clear lost");
    top_field_a: assert property (rp |=> reg_rdata[20:12] == $past(top_pending_number))
        else $error("top pending field wrong");
    reserved_zero_a: assert property (rp |=> reg_rdata[30:29] == 2'h0 && !reg_rdata[24]
        && !reg_rdata[21] && reg_rdata[11:9] == 3'h0) else $error("reserved bit set");
    offset_write_a: assert property (reg_sel && reg_write && reg_addr ==
        escb_pkg::ESCB_ADDR_VBASE |=> table_offset_q ==
        ($past(reg_wdata) & OFF_BUILT_MASK & escb_pkg::ESCB_OFF_MASK))
        else $error("offset write wrong");
endmodule
bind escb_regs escb_chk #(.OFF_BUILT_MASK(OFF_BUILT_MASK), .HAS_TICK(HAS_TICK)) escb_chk_inst (.*);

// File: verif/test_exception_state_and_vector_base_regs.sv
`timescale 1ns/1ps
module test_exception_state_and_vector_base_regs;
    localparam logic [31:0] P = escb_pkg::ESCB_ADDR_PEND;
    localparam logic [31:0] V = escb_pkg::ESCB_ADDR_VBASE;
    logic core_clk = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_write = 1'b0, tick_hw_set = 1'b0;
    logic external_irq_pending = 1'b0, service_on_halt_exit = 1'b0, nmi_taken, nmi_active;
    logic reg_ready, nonmaskable_pend_q, deferred_service_pend_q, tick_pend_q;
    logic [8:0] program_status_exception = 9'h000, top_pending_number;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, table_offset_q;
    int bad_count = 0, checked = 0;
    escb_regs escb_regs_inst (.cfg_table_offset(32'h0), .deferred_service_taken(1'b0),
        .tick_taken(1'b0), .*);
    escb_partner escb_partner_inst (.*);
    // 100 MHz core clock
    initial forever #5 core_clk = ~core_clk;
    // one access; answer lands one cycle after select
    task automatic acc(input logic w, input logic [31:0] a, d, e);
        @(posedge core_clk);
        {reg_sel, reg_write, reg_addr, reg_wdata} <= {1'b1, w, a, d};
        @(posedge core_clk);
        reg_sel <= 1'b0;
        #1 checked++;
        if (reg_ready !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED reg_ready at %h expected 1 seen %b", a, reg_ready);
        end
        if (!w && reg_rdata !== e) begin
            bad_count++;
            $display("CHECK FAILED reg_rdata at %h expected %h seen %h", a, e, reg_rdata);
        end
    endtask
    // write then read back
    task automatic sc(input logic [31:0] a, d, e);
        acc(1'b1, a, d, 32'h0);
        acc(1'b0, a, 32'h0, e);
        $display("test %h <- %h done", a, d);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // main sequence; extra edge after reset since an early offset write is lost
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        acc(1'b0, P, 32'h0, 32'h00000000);
        acc(1'b0, V, 32'h0, 32'h00000000);
        sc(V, 32'hFFFFFFFF, 32'hFFFFFF80);
        sc(P, 32'h10000000, 32'h1000E000);
        sc(P, 32'h00000000, 32'h1000E000);
        sc(P, 32'h08000000, 32'h00000000);
        sc(P, 32'h04000000, 32'h0400F000);
        sc(P, 32'h02000000, 32'h00000000);
        @(posedge core_clk);
        tick_hw_set <= 1'b1;
        @(posedge core_clk);
        tick_hw_set <= 1'b0;
        acc(1'b0, P, 32'h0, 32'h0400F000);
        sc(P, 32'h02000000, 32'h00000000);
        sc(P, 32'h80000000, 32'h80000000);
        @(posedge core_clk);
        {external_irq_pending, service_on_halt_exit, program_status_exception} <= 11'h603;
        acc(1'b0, P, 32'h0, 32'h80C00003);
        sc(32'hE000ED0C, 32'hFFFFFFFF, 32'h00000000);
        acc(1'b0, V, 32'h0, 32'hFFFFFF80);
        wrap_up;
    end
    // run needs well under 1 us; generous margin
    initial begin
        #20000;
        bad_count++;
        wrap_up;
    end
endmodule
